// ### bench/oxr_ext_mem.sv
// External data memory model that answers on the block's bus pins.
`timescale 1ns/1ps
module oxr_ext_mem (
    input wire logic clk,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    input wire logic ext_bus_en,
    input wire logic ext_rd_b,
    input wire logic ext_wr_b,
    output logic [7:0] ext_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // Cells never written read back 5A.
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h5A;
        end
    end
    // Stores on the write strobe and remembers the last value on the data pins.
    always @(posedge clk) begin
        if (ext_bus_en && !ext_wr_b) begin
            mem[ext_addr] <= ext_wdata;
        end
        last_q <= ext_rdata;
    end
    // Answers only during a read strobe; the released pins toggle every cycle.
    always @* begin
        if (ext_bus_en && !ext_rd_b) begin
            ext_rdata = mem[ext_addr];
        end else begin
            ext_rdata = ~last_q;
        end
    end
endmodule

// ### bench/test_onchip_xdata_ram_access.sv
// Self-checking bench for the on-chip external-data RAM access block.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
$display("MISMATCH t=%0t got %h want %h", $time, a, e); end end
module test_onchip_xdata_ram_access;
    import oxr_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic external_data_move_req = 1'b0;
    logic external_data_move_write = 1'b0;
    logic external_data_move_use_data_pointer_reg = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] index_register = 8'h00;
    logic [7:0] external_data_move_wdata = 8'h00;
    logic [15:0] data_pointer_reg = 16'h0000;
    wire logic [7:0] sfr_rdata, external_data_move_rdata, port_two_latch, ext_wdata, ext_rdata;
    wire logic [15:0] ext_addr;
    wire logic external_data_move_done, ext_bus_en, ext_rd_b, ext_wr_b;
    int miscompares = 0;
    int checks_done = 0;
    logic [7:0] rd;
    logic [2:0] stb;
    ////////////////////////////////////////////////////////////////////////////
    oxr_xdata_ram u_dut (.clk, .rst_b, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata,
        .external_data_move_req, .external_data_move_write, .external_data_move_use_data_pointer_reg, .data_pointer_reg, .index_register,
        .external_data_move_wdata, .external_data_move_rdata, .external_data_move_done, .port_two_latch, .ext_addr, .ext_wdata,
        .ext_bus_en, .ext_rd_b, .ext_wr_b, .ext_rdata);
    oxr_ext_mem u_mem (.clk, .ext_addr, .ext_wdata, .ext_bus_en, .ext_rd_b, .ext_wr_b,
        .ext_rdata);
    initial begin
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = !w;
        @(posedge clk);
        #1 sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(posedge clk);
        #1 rd = sfr_rdata;
    endtask
    // Raises a move request and returns just after the edge that takes it.
    task automatic start(input logic w, input logic dp, input logic [15:0] p,
            input logic [7:0] d);
        external_data_move_write = w;
        external_data_move_use_data_pointer_reg = dp;
        data_pointer_reg = p;
        index_register = p[7:0];
        external_data_move_wdata = d;
        external_data_move_req = 1'b1;
        @(posedge clk);
        #1 external_data_move_req = 1'b0;
    endtask
    // Whole move: strobes of the first busy cycle go to stb, the result to rd.
    task automatic external_data_move(input logic w, input logic dp, input logic [15:0] p,
            input logic [7:0] d);
        start(w, dp, p, d);
        stb = {ext_bus_en, ext_rd_b, ext_wr_b};
        repeat (2) @(posedge clk);
        #1 `CHK(external_data_move_done, 1'b1)
        rd = external_data_move_rdata;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_disabled();
        sfr(1'b0, OXR_CTRL_ADDR, 8'h00);
        `CHK(rd, 8'h01)
        sfr(1'b0, OXR_PAGE_ADDR, 8'h00);
        `CHK(rd, OXR_PAGE_RESET)
        `CHK(port_two_latch, 8'hFF)
        external_data_move(1'b1, 1'b1, 16'hF830, 8'hA5);
        `CHK({stb, ext_wdata, ext_addr}, {3'b110, 8'hA5, 16'hF830})
        external_data_move(1'b0, 1'b1, 16'hF830, 8'h00);
        `CHK({stb, rd}, {3'b101, 8'hA5})
    endtask
    task automatic t_enabled();
        sfr(1'b1, OXR_CTRL_ADDR, 8'h00);
        sfr(1'b1, OXR_CTRL_ADDR, 8'h01);
        sfr(1'b0, OXR_CTRL_ADDR, 8'h00);
        `CHK(rd, 8'h00)
        external_data_move(1'b1, 1'b1, 16'hF830, 8'h3C);
        `CHK(stb, 3'b011)
        external_data_move(1'b0, 1'b1, 16'hF830, 8'h00);
        `CHK({stb, rd}, {3'b011, 8'h3C})
        external_data_move(1'b1, 1'b1, 16'hF7FF, 8'h77);
        `CHK({stb, ext_addr}, {3'b110, 16'hF7FF})
        external_data_move(1'b0, 1'b1, 16'hFC00, 8'h00);
        `CHK({stb, rd}, {3'b011, OXR_UNBACKED_READ})
    endtask
    task automatic t_index();
        sfr(1'b1, OXR_PORT_TWO_ADDR, 8'hAA);
        sfr(1'b0, OXR_PAGE_ADDR, 8'h00);
        `CHK(rd, 8'hAA)
        sfr(1'b1, OXR_PAGE_ADDR, OXR_WINDOW_PAGE);
        `CHK(port_two_latch, 8'hAA)
        external_data_move(1'b0, 1'b0, 16'h0030, 8'h00);
        `CHK({stb, rd}, {3'b011, 8'h3C})
        sfr(1'b1, OXR_PAGE_ADDR, 8'h12);
        external_data_move(1'b0, 1'b0, 16'h0044, 8'h00);
        `CHK({stb, ext_addr, rd}, {3'b101, 16'hAA44, 8'h5A})
    endtask
    task automatic t_debug();
        sfr(1'b1, OXR_CTRL_ADDR, 8'h02);
        sfr(1'b0, OXR_CTRL_ADDR, 8'h00);
        `CHK(rd, 8'h02)
        external_data_move(1'b0, 1'b1, 16'hF830, 8'h00);
        `CHK({stb, rd}, {3'b101, 8'h3C})
    endtask
    task automatic t_reset_write();
        external_data_move(1'b1, 1'b1, 16'hFBFF, 8'h11);
        `CHK({stb, ext_wdata, ext_addr}, {3'b110, 8'h11, 16'hFBFF})
        start(1'b1, 1'b1, 16'hFBFF, 8'h22);
        do_reset();
        sfr(1'b1, OXR_CTRL_ADDR, 8'h00);
        external_data_move(1'b0, 1'b1, 16'hFBFF, 8'h00);
        `CHK(rd, 8'h11)
        start(1'b1, 1'b1, 16'hFBFF, 8'h33);
        @(posedge clk);
        #1 do_reset();
        sfr(1'b1, OXR_CTRL_ADDR, 8'h00);
        external_data_move(1'b0, 1'b1, 16'hFBFF, 8'h00);
        `CHK(rd, 8'h33)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #(5 * 2000);
        miscompares++;
        close_out();
    end
    initial begin
        @(posedge clk);
        #1 do_reset();
        t_disabled();
        t_enabled();
        t_index();
        t_debug();
        t_reset_write();
        close_out();
    end
endmodule

// ### hw/oxr_pkg.sv
// Constants and types for the on-chip external-data RAM access block.
package oxr_pkg;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] OXR_PAGE_ADDR = 8'h91;
    localparam logic [7:0] OXR_PORT_TWO_ADDR = 8'hA0;
    localparam logic [7:0] OXR_CTRL_ADDR = 8'hB1;
    localparam logic [7:0] OXR_PAGE_RESET = 8'h00;
    localparam logic [7:0] OXR_PORT_TWO_RESET = 8'hFF;
    localparam int OXR_CTRL_DIS_BIT = 0;
    localparam int OXR_CTRL_DBG_BIT = 1;
    localparam logic OXR_DISABLE_RESET = 1'b1;
    localparam logic OXR_DEBUG_RESET = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] OXR_WINDOW_PAGE = 8'hF8;
    localparam logic [15:0] OXR_WINDOW_BASE = 16'hF800;
    localparam logic [5:0] OXR_ARRAY_TAG = 6'h3E;
    localparam int OXR_ARRAY_AW = 10;
    localparam int OXR_ARRAY_WORDS = 1024;
    localparam logic [7:0] OXR_UNBACKED_READ = 8'hFF;
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        OXR_IDLE,
        OXR_CYC1,
        OXR_CYC2
    } oxr_fsm_t;
endpackage

// ### hw/oxr_xdata_ram.sv
// On-chip external-data RAM, page register, port two latch and move sequencer.
`timescale 1ns/1ps
// Notes on behaviour
// - Array contents survive reset, never initialised.
// - Array occupies F800 through FBFF.
// - Enabled RAM claims F800 to FFFF internally.
// - Enable changes one way; disabling only by reset.
// - Disabled RAM sends every move external.
// - A move takes two cycles.
// - Reset in first cycle aborts the store.
// - Reset in second cycle completes the store.
// - Pointer moves internal when enabled and pointer high.
// - Internal index moves address page high, index low.
// - Page register readable, writable, resets to zero.
// - Port two writes also load the page.
// - Page writes leave port two untouched.
// - Index moves internal only when page at least F8.
// - External index moves take upper byte from port.
// - Disable bit set only by reset, cleared once.
// - Debug bit shows bus and strobes internally.
module oxr_xdata_ram (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic external_data_move_req,
    input wire logic external_data_move_write,
    input wire logic external_data_move_use_data_pointer_reg,
    input wire logic [15:0] data_pointer_reg,
    input wire logic [7:0] index_register,
    input wire logic [7:0] external_data_move_wdata,
    output logic [7:0] external_data_move_rdata,
    output logic external_data_move_done,
    output logic [7:0] port_two_latch,
    output logic [15:0] ext_addr,
    output logic [7:0] ext_wdata,
    output logic ext_bus_en,
    output logic ext_rd_b,
    output logic ext_wr_b,
    input wire logic [7:0] ext_rdata
);
    import oxr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.
    logic rst_meta_q;
    logic rst_ok_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_ok_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_ok_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Block state apart from the array and the reset flip-flops.
    typedef struct packed {
        oxr_fsm_t fsm;
        logic [7:0] page;
        logic [7:0] port_two;
        logic ram_disable;
        logic debug;
        logic [7:0] sfr_rdata;
        logic op_write;
        logic op_internal;
        logic [15:0] op_addr;
        logic [7:0] op_wdata;
        logic [7:0] external_data_move_rdata;
        logic done;
        logic [15:0] ext_addr;
        logic [7:0] ext_wdata;
        logic ext_bus_en;
        logic ext_rd_b;
        logic ext_wr_b;
        logic [7:0] ext_meta;
    } oxr_state_t;

    oxr_state_t st_q;
    oxr_state_t st_d;

    logic [7:0] ram_array [OXR_ARRAY_WORDS];
    logic [OXR_ARRAY_AW-1:0] op_index;
    logic op_backed;
    logic [15:0] req_addr;
    logic req_internal;
    logic show_bus;

    assign op_index = st_q.op_addr[OXR_ARRAY_AW-1:0];
    assign op_backed = (st_q.op_addr[15:OXR_ARRAY_AW] == OXR_ARRAY_TAG);

    ////////////////////////////////////////////////////////////////////////////
    // Address formation and internal decode of a new move.
    always_comb begin
        if (external_data_move_use_data_pointer_reg) begin
            req_addr = data_pointer_reg;
            req_internal = !st_q.ram_disable && (data_pointer_reg >= OXR_WINDOW_BASE);
        end else begin
            req_internal = !st_q.ram_disable && (st_q.page >= OXR_WINDOW_PAGE);
            if (req_internal) begin
                req_addr = {st_q.page, index_register};
            end else begin
                req_addr = {st_q.port_two, index_register};
            end
        end
        // Disabled RAM forces external routing above.
        show_bus = !req_internal || st_q.debug;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.ext_meta = ext_rdata;
        if (sfr_wr) begin
            case (sfr_addr)
                OXR_PAGE_ADDR: begin
                    st_d.page = sfr_wdata;
                end
                OXR_PORT_TWO_ADDR: begin
                    st_d.port_two = sfr_wdata;
                    st_d.page = sfr_wdata;
                end
                OXR_CTRL_ADDR: begin
                    st_d.ram_disable = st_q.ram_disable & sfr_wdata[OXR_CTRL_DIS_BIT];
                    st_d.debug = sfr_wdata[OXR_CTRL_DBG_BIT];
                end
                default: begin
                end
            endcase
        end
        if (sfr_rd) begin
            case (sfr_addr)
                OXR_PAGE_ADDR: st_d.sfr_rdata = st_q.page;
                OXR_PORT_TWO_ADDR: st_d.sfr_rdata = st_q.port_two;
                OXR_CTRL_ADDR: st_d.sfr_rdata = {6'h00, st_q.debug, st_q.ram_disable};
                default: st_d.sfr_rdata = 8'h00;
            endcase
        end
        case (st_q.fsm)
            OXR_IDLE: begin
                if (external_data_move_req) begin
                    st_d.fsm = OXR_CYC1;
                    st_d.op_write = external_data_move_write;
                    st_d.op_internal = req_internal;
                    st_d.op_addr = req_addr;
                    st_d.op_wdata = external_data_move_wdata;
                    st_d.ext_bus_en = show_bus;
                    st_d.ext_addr = req_addr;
                    st_d.ext_wdata = external_data_move_wdata;
                    st_d.ext_rd_b = !(show_bus && !external_data_move_write);
                    st_d.ext_wr_b = !(show_bus && external_data_move_write);
                end
            end
            OXR_CYC1: begin
                st_d.fsm = OXR_CYC2;
                if (st_q.op_internal && !st_q.op_write) begin
                    st_d.external_data_move_rdata = op_backed ? ram_array[op_index] : OXR_UNBACKED_READ;
                end
            end
            OXR_CYC2: begin
                st_d.fsm = OXR_IDLE;
                st_d.done = 1'b1;
                if (!st_q.op_internal && !st_q.op_write) begin
                    st_d.external_data_move_rdata = st_q.ext_meta;
                end
                st_d.ext_bus_en = 1'b0;
                st_d.ext_rd_b = 1'b1;
                st_d.ext_wr_b = 1'b1;
            end
            default: begin
                st_d.fsm = OXR_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers. Reset detection uses the synchronised copy.
    always_ff @(posedge clk or negedge rst_ok_q) begin
        if (!rst_ok_q) begin
            st_q <= '0;
            st_q.fsm <= OXR_IDLE;
            st_q.page <= OXR_PAGE_RESET;
            st_q.port_two <= OXR_PORT_TWO_RESET;
            st_q.ram_disable <= OXR_DISABLE_RESET;
            st_q.debug <= OXR_DEBUG_RESET;
            st_q.ext_rd_b <= 1'b1;
            st_q.ext_wr_b <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // The array has no reset so its contents survive any reset.
    // The store commits at the end of the first cycle, so a reset seen in
    // the first cycle kills it and one seen in the second does not.
    always_ff @(posedge clk) begin
        if (rst_ok_q && st_q.fsm == OXR_CYC1 && st_q.op_write && st_q.op_internal && op_backed) begin
            ram_array[op_index] <= st_q.op_wdata;
        end
    end

    assign sfr_rdata = st_q.sfr_rdata;
    assign external_data_move_rdata = st_q.external_data_move_rdata;
    assign external_data_move_done = st_q.done;
    assign port_two_latch = st_q.port_two;
    assign ext_addr = st_q.ext_addr;
    assign ext_wdata = st_q.ext_wdata;
    assign ext_bus_en = st_q.ext_bus_en;
    assign ext_rd_b = st_q.ext_rd_b;
    assign ext_wr_b = st_q.ext_wr_b;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_ok_q);

    sequence idle_req_s;
        st_q.fsm == OXR_IDLE && external_data_move_req;
    endsequence
    sequence two_cycles_s;
        st_q.fsm == OXR_CYC1 ##1 st_q.fsm == OXR_CYC2 ##1 external_data_move_done;
    endsequence
    sequence bus_shown_s;
        ext_bus_en && !ext_rd_b != !ext_wr_b;
    endsequence
    sequence bus_released_s;
        !ext_bus_en && ext_rd_b && ext_wr_b;
    endsequence

    move_length_a: assert property (idle_req_s |=> two_cycles_s)
        else $error("Move did not finish in two cycles.");

    bus_release_a: assert property (st_q.fsm == OXR_CYC2 |=> bus_released_s)
        else $error("Bus was not released when the move ended.");

    port_mirror_a: assert property (sfr_wr && sfr_addr == OXR_PORT_TWO_ADDR
        |=> st_q.page == $past(sfr_wdata) && port_two_latch == $past(sfr_wdata))
        else $error("Port two write did not load the page.");

    page_only_a: assert property (sfr_wr && sfr_addr == OXR_PAGE_ADDR
        |=> $stable(port_two_latch) && st_q.page == $past(sfr_wdata))
        else $error("Page write disturbed port two.");

    page_read_a: assert property (sfr_rd && sfr_addr == OXR_PAGE_ADDR
        |=> sfr_rdata == $past(st_q.page))
        else $error("Page read returned the wrong value.");

    ctrl_read_a: assert property (sfr_rd && sfr_addr == OXR_CTRL_ADDR
        |=> sfr_rdata[7:2] == 6'h00 && sfr_rdata[0] == $past(st_q.ram_disable))
        else $error("Control read returned the wrong value.");

    enable_sticky_a: assert property (!st_q.ram_disable |=> !st_q.ram_disable)
        else $error("Disabled RAM came back without reset.");

    quiet_strobes_a: assert property ((idle_req_s and req_internal && !st_q.debug)
        |=> (ext_rd_b && ext_wr_b && !ext_bus_en)[*2])
        else $error("Internal move drove the external bus.");

    debug_bus_a: assert property ((idle_req_s and req_internal && st_q.debug)
        |=> bus_shown_s ##1 bus_shown_s)
        else $error("Debug move did not show the bus.");

    write_data_a: assert property ((idle_req_s and show_bus && external_data_move_write)
        |=> ext_wdata == $past(external_data_move_wdata) && !ext_wr_b)
        else $error("Bus write did not carry the move data.");

    disabled_external_a: assert property ((idle_req_s and st_q.ram_disable)
        |=> !st_q.op_internal && ext_bus_en)
        else $error("Disabled RAM still served a move.");

    index_page_a: assert property ((idle_req_s and !external_data_move_use_data_pointer_reg
        && !st_q.ram_disable && st_q.page >= OXR_WINDOW_PAGE)
        |=> st_q.op_internal && st_q.op_addr == {$past(st_q.page), $past(index_register)})
        else $error("Index move formed the wrong internal address.");

    index_external_a: assert property ((idle_req_s and !external_data_move_use_data_pointer_reg
        && st_q.page < OXR_WINDOW_PAGE) |=> !st_q.op_internal && ext_bus_en)
        else $error("Low page index move stayed internal.");

    index_port_a: assert property ((idle_req_s and !external_data_move_use_data_pointer_reg
        && st_q.page < OXR_WINDOW_PAGE)
        |=> ext_addr[15:8] == $past(st_q.port_two) && !ext_rd_b != !ext_wr_b)
        else $error("External index move used the wrong upper byte.");

    pointer_decode_a: assert property ((idle_req_s and external_data_move_use_data_pointer_reg)
        |=> st_q.op_internal == $past(!st_q.ram_disable
        && data_pointer_reg >= OXR_WINDOW_BASE))
        else $error("Pointer move decoded wrongly.");

    internal_read_a: assert property (st_q.fsm == OXR_CYC1 && st_q.op_internal
        && !st_q.op_write && op_backed |=> external_data_move_rdata == $past(ram_array[op_index]))
        else $error("Internal read did not return the array byte.");

    unbacked_read_a: assert property (st_q.fsm == OXR_CYC1 && st_q.op_internal
        && !st_q.op_write && !op_backed |=> external_data_move_rdata == OXR_UNBACKED_READ)
        else $error("Claimed read above the array returned the wrong value.");

    store_lands_a: assert property (st_q.fsm == OXR_CYC1 && st_q.op_write
        && st_q.op_internal && op_backed |=> ram_array[$past(op_index)] == $past(st_q.op_wdata))
        else $error("Internal store did not land.");
endmodule
